/* core/flr_pkg.sv */
// Package of constants and types for the fault latch and auto-retry controller
// How it works
// - Any internal fault event shuts output down
// - Fault stays latched after cause clears
// - Supply or enable undervoltage clears the latch
// - Auto-retry sequencer may also clear latch
// - Delay strap shorted means latch-off only
// - Both straps open: four retries, minimum delay
// - Delay open, count shorted: endless retries
// - Both capacitors: delay and ratio count
// - Delay capacitor, count open: four retries
// - Delay capacitor, count shorted: endless retries
// - Delay is 128 strap oscillator cycles
// - Nominal count is four times charge ratio
// - Count rounds up to power-of-four level
// - Seven quiet delays reset retry count
// - Enable low disables; handshake low means on
// - Handshake low or resets restart after timeout
// - Thermal fault waits for temperature clear
package flr_pkg;
    // Strap decode: shorted, open, or capacitor-programmed
    typedef enum logic [1:0] {
        FLR_STRAP_SHORT = 2'h0,
        FLR_STRAP_OPEN = 2'h1,
        FLR_STRAP_CAP = 2'h3
    } flr_strap_t;
    // Sequencer states, Gray coded along run -> fault -> wait
    typedef enum logic [1:0] {
        FLR_ST_RUN = 2'h0,
        FLR_ST_LATCHED = 2'h1,
        FLR_ST_WAIT = 2'h3,
        FLR_ST_LOCKED = 2'h2
    } flr_state_t;
    // Oscillator charge cycles per retry delay
    localparam int FLR_DELAY_CYCLES = 128;
    // Quiet periods that reset the retry count
    localparam int FLR_QUIET_PERIODS = 7;
    // Multiplier of the nominal count
    localparam int FLR_COUNT_SCALE = 4;
    // Default count with count strap open
    localparam logic [10:0] FLR_DEFAULT_RETRIES = 11'h004;
    // Quantized retry levels
    localparam logic [10:0] FLR_LEVEL_0 = 11'h004;
    localparam logic [10:0] FLR_LEVEL_1 = 11'h010;
    localparam logic [10:0] FLR_LEVEL_2 = 11'h040;
    localparam logic [10:0] FLR_LEVEL_3 = 11'h100;
    localparam logic [10:0] FLR_LEVEL_4 = 11'h400;
    // Minimum oscillator period in system clocks (open delay strap)
    localparam int FLR_MIN_OSC_CLKS = 4;
    // Width of the measured oscillator period
    localparam int FLR_PERIOD_W = 16;
endpackage

/* core/flr_osc_tick.sv */
// Programmable tick generator: one pulse every period_clks clocks
`timescale 1ns/1ns
module flr_osc_tick #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run,
    input wire logic [W-1:0] period_clks,
    output logic tick
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic tick_next;
    logic tick_reg;

    // Counts up while run is high; restarts on each tick or when idle
    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (!run) begin
            cnt_next = '0;
        end else if (cnt_reg + W'(1) >= period_clks) begin
            cnt_next = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    // Registers only
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

/* core/flr_ctrl.sv */
// Fault latch, auto-retry sequencer and enable/handshake decode
`timescale 1ns/1ns
module flr_ctrl #(
    parameter int PW = flr_pkg::FLR_PERIOD_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    // Fault sources and thermal clear flag (pins, synchronised here)
    input wire logic thermal_trip_level,
    input wire logic thermal_clear_hys,
    input wire logic breaker_trip,
    input wire logic blanking_timer_pin_short,
    input wire logic current_limit_pin_short,
    // External reset sources and load handshake inputs
    input wire logic supply_undervoltage_fall_level,
    input wire logic enable_undervoltage_input,
    input wire logic load_handshake_input,
    input wire logic handshake_timeout,
    // Decoded strap states
    input wire logic [1:0] retry_delay_strap,
    input wire logic [1:0] retry_count_strap,
    // Measured delay-strap oscillator period, in clocks
    input wire logic [PW-1:0] delay_osc_clks,
    // Measured count-strap charge time, in clocks
    input wire logic [PW+11:0] count_charge_clks,
    // Outputs
    output logic output_on,
    output logic device_disabled,
    output logic fault_latched,
    output logic retry_locked,
    output logic [10:0] retry_count
);
    // Two-flop synchronisers for all pin inputs
    logic [8:0] s1_reg;
    logic [8:0] s2_reg;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= {thermal_trip_level, thermal_clear_hys, breaker_trip, blanking_timer_pin_short,
                       current_limit_pin_short, supply_undervoltage_fall_level, enable_undervoltage_input,
                       load_handshake_input, handshake_timeout};
            s2_reg <= s1_reg;
        end
    end
    logic ot;
    logic ot_clear;
    logic uv_supply;
    logic en_in;
    logic hs_in;
    logic hs_to;
    logic fault_evt;
    assign ot = s2_reg[8];
    assign ot_clear = s2_reg[7];
    assign uv_supply = s2_reg[3];
    assign en_in = s2_reg[2];
    assign hs_in = s2_reg[1];
    assign hs_to = s2_reg[0];
    assign fault_evt = ot | s2_reg[6] | s2_reg[5] | s2_reg[4];

    // External latch reset: supply or enable undervoltage
    logic ext_clr;
    assign ext_clr = uv_supply | ~en_in;

    // Strap decode
    flr_pkg::flr_strap_t dly_strap;
    flr_pkg::flr_strap_t cnt_strap;
    assign dly_strap = flr_pkg::flr_strap_t'(retry_delay_strap);
    assign cnt_strap = flr_pkg::flr_strap_t'(retry_count_strap);

    // Oscillator period: minimum when open, measured when capacitor
    logic [PW-1:0] osc_period;
    always_comb begin
        if (dly_strap == flr_pkg::FLR_STRAP_CAP) begin
            osc_period = delay_osc_clks;
        end else begin
            osc_period = PW'(flr_pkg::FLR_MIN_OSC_CLKS);
        end
    end

    // Nominal count 4*charge/period, rounded up to a power-of-four level
    logic [10:0] count_limit;
    logic unlimited;
    logic [PW+13:0] nom_x;
    assign nom_x = (PW+14)'(count_charge_clks) * (PW+14)'(flr_pkg::FLR_COUNT_SCALE);
    always_comb begin
        unlimited = (cnt_strap == flr_pkg::FLR_STRAP_SHORT);
        if (cnt_strap == flr_pkg::FLR_STRAP_OPEN) begin
            count_limit = flr_pkg::FLR_DEFAULT_RETRIES;
        end else if (nom_x <= (PW+14)'(osc_period) * (PW+14)'(flr_pkg::FLR_LEVEL_0)) begin
            count_limit = flr_pkg::FLR_LEVEL_0;
        end else if (nom_x <= (PW+14)'(osc_period) * (PW+14)'(flr_pkg::FLR_LEVEL_1)) begin
            count_limit = flr_pkg::FLR_LEVEL_1;
        end else if (nom_x <= (PW+14)'(osc_period) * (PW+14)'(flr_pkg::FLR_LEVEL_2)) begin
            count_limit = flr_pkg::FLR_LEVEL_2;
        end else if (nom_x <= (PW+14)'(osc_period) * (PW+14)'(flr_pkg::FLR_LEVEL_3)) begin
            count_limit = flr_pkg::FLR_LEVEL_3;
        end else begin
            count_limit = flr_pkg::FLR_LEVEL_4; // Saturates at top level
        end
    end

    // Oscillator tick; runs whenever no external clear is active so quiet time counts
    logic osc_tick;
    flr_osc_tick #(.W(PW)) u_osc (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(~ext_clr),
        .period_clks(osc_period),
        .tick(osc_tick)
    );

    // Sequencer state
    flr_pkg::flr_state_t st_reg;
    flr_pkg::flr_state_t st_next;
    logic [7:0] osc_cnt_reg;
    logic [7:0] osc_cnt_next;
    logic [2:0] quiet_reg;
    logic [2:0] quiet_next;
    logic [10:0] retries_reg;
    logic [10:0] retries_next;
    logic hs_off_reg;
    logic hs_off_next;
    logic delay_done;
    assign delay_done = osc_tick && (osc_cnt_reg == 8'(flr_pkg::FLR_DELAY_CYCLES - 1));

    // Next-state logic for latch, retry timer, retry count and quiet timer
    always_comb begin
        st_next = st_reg;
        osc_cnt_next = osc_cnt_reg;
        quiet_next = quiet_reg;
        retries_next = retries_reg;
        hs_off_next = hs_off_reg;
        // Delay period counter free-runs in 128-tick periods
        if (osc_tick) begin
            osc_cnt_next = delay_done ? 8'h00 : osc_cnt_reg + 8'h01;
        end
        // Handshake timeout latches off until handshake pulled low
        if (hs_to) begin
            hs_off_next = 1'b1;
        end else if (!hs_in) begin
            hs_off_next = 1'b0;
        end
        if (ext_clr) begin
            // External reset clears everything and wins
            st_next = flr_pkg::FLR_ST_RUN;
            osc_cnt_next = 8'h00;
            quiet_next = 3'h0;
            retries_next = 11'h000;
            hs_off_next = 1'b0;
        end else begin
            case (st_reg)
                flr_pkg::FLR_ST_RUN: begin
                    if (fault_evt) begin
                        st_next = flr_pkg::FLR_ST_LATCHED;
                        quiet_next = 3'h0;
                    end else if (delay_done && retries_reg != 11'h000) begin
                        // Quiet period count, measured from the last retry release
                        if (quiet_reg == 3'(flr_pkg::FLR_QUIET_PERIODS - 1)) begin
                            retries_next = 11'h000;
                            quiet_next = 3'h0;
                        end else begin
                            quiet_next = quiet_reg + 3'h1;
                        end
                    end
                end
                flr_pkg::FLR_ST_LATCHED: begin
                    // Held until cause gone and thermal hysteresis cleared; the trip pin
                    // drops at the trip level, so only the hysteresis flag says the die is cool
                    if (fault_evt || !ot_clear) begin
                        st_next = flr_pkg::FLR_ST_LATCHED;
                    end else if (dly_strap == flr_pkg::FLR_STRAP_SHORT) begin
                        st_next = flr_pkg::FLR_ST_LOCKED;
                    end else if (!unlimited && retries_reg >= count_limit) begin
                        st_next = flr_pkg::FLR_ST_LOCKED;
                    end else begin
                        st_next = flr_pkg::FLR_ST_WAIT;
                        osc_cnt_next = 8'h00;
                    end
                end
                flr_pkg::FLR_ST_WAIT: begin
                    // One full retry delay, then the latch releases
                    if (delay_done) begin
                        st_next = flr_pkg::FLR_ST_RUN;
                        quiet_next = 3'h0;
                        if (!unlimited) begin
                            retries_next = retries_reg + 11'h001;
                        end
                    end
                end
                flr_pkg::FLR_ST_LOCKED: begin
                    st_next = flr_pkg::FLR_ST_LOCKED;
                end
                default: begin
                    st_next = flr_pkg::FLR_ST_LATCHED;
                end
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_reg <= flr_pkg::FLR_ST_RUN;
            osc_cnt_reg <= 8'h00;
            quiet_reg <= 3'h0;
            retries_reg <= 11'h000;
            hs_off_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            osc_cnt_reg <= osc_cnt_next;
            quiet_reg <= quiet_next;
            retries_reg <= retries_next;
            hs_off_reg <= hs_off_next;
        end
    end

    // Output decode registered so data outputs come from flops
    logic on_reg;
    logic dis_reg;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            on_reg <= 1'b0;
            dis_reg <= 1'b1;
        end else begin
            dis_reg <= ~en_in;
            on_reg <= en_in && !uv_supply && !hs_in && !hs_off_reg && st_reg == flr_pkg::FLR_ST_RUN;
        end
    end

    assign output_on = on_reg;
    assign device_disabled = dis_reg;
    assign fault_latched = (st_reg != flr_pkg::FLR_ST_RUN);
    assign retry_locked = (st_reg == flr_pkg::FLR_ST_LOCKED);
    assign retry_count = retries_reg;
endmodule

/* verification/flr_handshake_model.sv */
// Load handshake pin and its timing capacitor
`timescale 1ns/1ns
module flr_handshake_model #(
    parameter int CHARGE_CLKS = 40
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic load_present,
    output logic load_handshake_input,
    output logic handshake_timeout
);
    int charge_cnt;
    // Present load pulls the pin low, else the pull-up wins
    assign load_handshake_input = !load_present;
    // Capacitor charges only while the pin is released
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            charge_cnt <= 0;
        end else if (load_present) begin
            charge_cnt <= 0;
        end else if (charge_cnt < CHARGE_CLKS) begin
            charge_cnt <= charge_cnt + 1;
        end
    end
    assign handshake_timeout = (charge_cnt >= CHARGE_CLKS);
endmodule

/* verification/flr_ctrl_checker.sv */
// Port assertions for the fault latch and retry controller
`timescale 1ns/1ns
module flr_ctrl_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic thermal_trip_level,
    input wire logic breaker_trip,
    input wire logic supply_undervoltage_fall_level,
    input wire logic enable_undervoltage_input,
    input wire logic load_handshake_input,
    input wire logic [1:0] retry_delay_strap,
    input wire logic output_on,
    input wire logic device_disabled,
    input wire logic fault_latched,
    input wire logic retry_locked,
    input wire logic [10:0] retry_count
);
    // No external clear pending
    wire logic en_ok = enable_undervoltage_input && !supply_undervoltage_fall_level;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Held long enough to pass the input synchronisers
    sequence s_trip;
        (breaker_trip && en_ok) [*5];
    endsequence
    sequence s_steady;
        en_ok [*4];
    endsequence
    chk_trip_latch: assert property (s_trip |-> fault_latched)
        else $error("breaker trip not latched");
    chk_hot_dark: assert property ((thermal_trip_level && en_ok) [*5] |-> fault_latched && !output_on)
        else $error("hot die left output on");
    chk_latch_dark: assert property (fault_latched [*2] |-> !output_on)
        else $error("output on while latched");
    chk_disable_clear: assert property ((!enable_undervoltage_input) [*4] |-> device_disabled && !output_on
        && !fault_latched)
        else $error("enable low not honoured");
    chk_uv_clear: assert property (supply_undervoltage_fall_level [*4] |-> !fault_latched && !retry_locked
        && retry_count == 11'h000)
        else $error("undervoltage did not clear");
    chk_hs_off: assert property (load_handshake_input [*4] |-> !output_on)
        else $error("output on with handshake high");
    chk_no_retry: assert property (s_steady ##0 (fault_latched && retry_delay_strap == flr_pkg::FLR_STRAP_SHORT)
        |=> fault_latched)
        else $error("latch released in latch-off mode");
    chk_lock_hold: assert property (s_steady ##0 retry_locked |=> retry_locked)
        else $error("lock released without external clear");
    chk_lock_level: assert property ($rose(retry_locked) && retry_delay_strap != flr_pkg::FLR_STRAP_SHORT
        |-> retry_count inside {11'h004, 11'h010, 11'h040,
        11'h100, 11'h400})
        else $error("lock at unquantized count");
    chk_count_step: assert property (retry_count != $past(retry_count) |-> retry_count == 11'h000
        || retry_count == $past(retry_count) + 11'h001)
        else $error("retry count jumped");
endmodule
bind flr_ctrl flr_ctrl_checker u_chk (.clk_sys, .reset, .thermal_trip_level, .breaker_trip,
    .supply_undervoltage_fall_level, .enable_undervoltage_input, .load_handshake_input, .retry_delay_strap,
    .output_on, .device_disabled, .fault_latched, .retry_locked, .retry_count);

/* verification/flr_ctrl_tb_top.sv */
// Self-checking bench for the fault latch and retry controller
`timescale 1ns/1ns
module flr_ctrl_tb_top;
    typedef struct {logic [1:0] d; logic [1:0] c; logic [27:0] chg; logic [3:0] src; int nf;
        logic [10:0] rel; logic lk;} flr_row_t;
    localparam logic [1:0] SH = flr_pkg::FLR_STRAP_SHORT;
    localparam logic [1:0] OP = flr_pkg::FLR_STRAP_OPEN;
    localparam logic [1:0] CP = flr_pkg::FLR_STRAP_CAP;
    // Strap mode, count-strap charge, fault source, faults, releases, locked
    flr_row_t rows [7] = '{'{OP, OP, 28'h0, 4'h4, 5, 11'h004, 1'h1}, '{OP, SH, 28'h0, 4'h2, 6, 11'h006, 1'h0},
        '{CP, CP, 28'hc, 4'h1, 17, 11'h010, 1'h1}, '{CP, CP, 28'h6, 4'h4, 5, 11'h004, 1'h1},
        '{CP, OP, 28'h0, 4'h1, 5, 11'h004, 1'h1}, '{CP, SH, 28'h0, 4'h8, 4, 11'h004, 1'h0},
        '{SH, OP, 28'h0, 4'h4, 1, 11'h000, 1'h1}};
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic [3:0] fault_vec = 4'h0; // Thermal, breaker, blanking, limit
    logic clear_hys = 1'h1;
    logic uv = 1'h0;
    logic en = 1'h1;
    logic load_present = 1'h1;
    logic [1:0] dly = OP;
    logic [1:0] cnt = OP;
    logic [27:0] chg = 28'h0;
    logic output_on, device_disabled, fault_latched, retry_locked, hs, hs_to;
    logic [10:0] retry_count;
    int n_mismatch = 0;
    int n_checks = 0;
    always #10 clk_sys = !clk_sys;
    flr_handshake_model u_hs (.clk_sys, .reset, .load_present, .load_handshake_input(hs), .handshake_timeout(hs_to));
    flr_ctrl u_dut (.clk_sys, .reset, .thermal_trip_level(fault_vec[3]), .thermal_clear_hys(clear_hys),
        .breaker_trip(fault_vec[2]), .blanking_timer_pin_short(fault_vec[1]), .current_limit_pin_short(fault_vec[0]),
        .supply_undervoltage_fall_level(uv), .enable_undervoltage_input(en), .load_handshake_input(hs),
        .handshake_timeout(hs_to), .retry_delay_strap(dly), .retry_count_strap(cnt), .delay_osc_clks(16'h0006),
        .count_charge_clks(chg), .output_on, .device_disabled, .fault_latched, .retry_locked, .retry_count);
    task automatic chk_val(input string nm, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One fault pulse, then wait for the sequencer to release or give up
    task automatic fault_once(input logic [3:0] src, input int per, output logic rel);
        int w;
        fault_vec <= src;
        clear_hys <= !src[3];
        clk(6);
        fault_vec <= 4'h0;
        clear_hys <= 1'h1;
        for (w = 0; fault_latched === 1'h1 && retry_locked !== 1'h1 && w < 3000; w++) clk(1);
        rel = (fault_latched === 1'h0);
        if (rel) chk_val("retry_delay", 1, w >= 127 * per && w <= 130 * per + 12);
        clk(2);
        chk_val("output_on", rel, output_on);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk(60000);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        int nrel;
        logic r;
        clk(20);
        chk_val("disabled_in_reset", 1, device_disabled);
        chk_val("on_in_reset", 0, output_on);
        reset <= 1'h0;
        clk(8);
        chk_val("on_after_reset", 1, output_on);
        foreach (rows[i]) begin
            dly <= rows[i].d;
            cnt <= rows[i].c;
            chg <= rows[i].chg;
            nrel = 0;
            clk(8);
            repeat (rows[i].nf) begin
                fault_once(rows[i].src, rows[i].d == CP ? 6 : flr_pkg::FLR_MIN_OSC_CLKS, r);
                nrel += r;
            end
            chk_val("releases", rows[i].rel, 11'(nrel));
            chk_val("locked", rows[i].lk, retry_locked);
            if (rows[i].lk) chk_val("count_at_lock", rows[i].rel, retry_count);
            uv <= i[0];
            en <= i[0];
            clk(8);
            chk_val("cleared_latch", 0, fault_latched);
            chk_val("cleared_lock", 0, retry_locked);
            chk_val("cleared_count", 0, retry_count);
            chk_val("disabled", i[0] ? 11'h000 : 11'h001, device_disabled);
            uv <= 1'h0;
            en <= 1'h1;
        end
        dly <= OP;
        cnt <= OP;
        clk(8);
        repeat (2) fault_once(4'h4, 4, r);
        chk_val("count_two", 2, retry_count);
        clk(8 * 512);
        chk_val("count_quiet", 0, retry_count);
        fault_vec <= 4'h8;
        clear_hys <= 1'h0;
        clk(6);
        fault_vec <= 4'h0;
        clk(1500);
        chk_val("hot_hold", 1, fault_latched);
        clear_hys <= 1'h1;
        clk(700);
        chk_val("hot_retry", 0, fault_latched);
        load_present <= 1'h0;
        clk(60);
        chk_val("hs_off", 0, output_on);
        load_present <= 1'h1;
        clk(8);
        chk_val("hs_on", 1, output_on);
        print_verdict();
    end
endmodule
